/* File: core/acc_defines.svh */
// Constants for the alarm contact controller
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ------------------------------------------------------------
// Contact counts
// ------------------------------------------------------------
`define ACC_N_BASE_IN 12
`define ACC_N_CFG_IO 4
`define ACC_N_IN 32
`define ACC_N_OUT 16
`define ACC_N_PANEL_OUT 12
`define ACC_N_VWIRE 4
`define ACC_DESC_LEN 63

// ------------------------------------------------------------
// Field widths
// ------------------------------------------------------------
`define ACC_SEV_W 3
`define ACC_TRIG_W 2
`define ACC_FORCE_W 2
`define ACC_VW_W 2
`define ACC_IDX_W 5
`define ACC_POS_W 6

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ACC_CLK_KHZ 100000
`define ACC_FLASH_HALF_MS 250

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ACC_IN_RST 32'h0000_0000
`define ACC_OUT_RST 16'h0000
`define ACC_CHAR_RST 8'h00

`endif

/* File: core/acc_pkg.sv */
// Types for the alarm contact controller
package acc_pkg;

    // --------------------------------------------------------
    // Severity, ordered lowest to highest
    // --------------------------------------------------------
    typedef enum logic [2:0] {
        ACC_SEV_NOT_REPORTED = 3'h0,
        ACC_SEV_NOT_ALARMED = 3'h1,
        ACC_SEV_MINOR = 3'h2,
        ACC_SEV_MAJOR = 3'h3,
        ACC_SEV_CRITICAL = 3'h4
    } acc_sev_e;

    // --------------------------------------------------------
    // Output trigger source and manual force
    // --------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_TRIG_MANUAL = 2'h0,
        ACC_TRIG_LOCAL = 2'h1,
        ACC_TRIG_REMOTE = 2'h2,
        ACC_TRIG_VWIRE = 2'h3
    } acc_trig_e;

    typedef enum logic [1:0] {
        ACC_FORCE_NONE = 2'h0,
        ACC_FORCE_OPEN = 2'h1,
        ACC_FORCE_CLOSE = 2'h2
    } acc_force_e;

endpackage

/* File: core/acc_ctrl.sv */
// Alarm contact controller: inputs, control outputs, faceplate indicators
`timescale 1ns/100ps
`include "acc_defines.svh"

module acc_ctrl #(
    parameter int FLASH_HALF_CYC =
        `ACC_FLASH_HALF_MS * (`ACC_CLK_KHZ)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Contact pins, closed = 1
    input wire logic [31:0] contact_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    output logic [11:0] panel_out,
    // Block setup
    input wire logic block_enable,
    input wire logic panel_attached,
    input wire logic [3:0] io_dir_out,
    // Per-input provisioning
    input wire logic [31:0] in_provisioned,
    input wire logic [31:0] in_alarm_on_open,
    input wire logic [95:0] in_severity,
    input wire logic [31:0] in_svc_affect,
    input wire logic [31:0] in_vwire_en,
    input wire logic [63:0] in_vwire_sel,
    // Description store
    input wire logic desc_wr,
    input wire logic [4:0] desc_wr_idx,
    input wire logic [5:0] desc_wr_pos,
    input wire logic [7:0] desc_wr_char,
    input wire logic [4:0] desc_rd_idx,
    input wire logic [5:0] desc_rd_pos,
    output logic [7:0] desc_rd_char,
    // Per-output provisioning
    input wire logic [31:0] out_trig_mode,
    input wire logic [47:0] out_trig_level,
    input wire logic [31:0] out_vwire_sel,
    input wire logic [31:0] out_force,
    // Remote alarm summary
    input wire logic remote_alarm_valid,
    input wire logic [2:0] remote_max_sev,
    // Alarm status
    output logic [31:0] alarm_active,
    output logic [31:0] alarm_svc_affect,
    output logic [15:0] out_closed,
    output logic [3:0] vwire,
    // Indicator sources
    input wire logic pwr_a_ok,
    input wire logic pwr_b_ok,
    input wire logic ring_local_call,
    input wire logic ring_express_call,
    input wire logic cpu_ready,
    input wire logic booting,
    // Faceplate indicators
    output logic input_led,
    output logic output_led,
    output logic pwr_a_green,
    output logic pwr_a_red,
    output logic pwr_b_green,
    output logic pwr_b_red,
    output logic ring_local_led,
    output logic ring_express_led,
    output logic fail_led,
    output logic act_led
);

    // ------------------------------------------------------------
    // Contact synchroniser
    // ------------------------------------------------------------
    logic [31:0] sync_a;
    logic [31:0] sync_b;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= `ACC_IN_RST;
            sync_b <= `ACC_IN_RST;
        end else begin
            sync_a <= contact_in;
            sync_b <= sync_a;
        end
    end

    // ------------------------------------------------------------
    // Input alarm evaluation
    // ------------------------------------------------------------
    // Level-based: no latching, so an alarm falls as soon as the
    // contact returns or provisioning is withdrawn.
    logic [31:0] in_usable;
    logic [31:0] next_alarm;
    logic [31:0] next_svc;

    always_comb begin
        // Pins 12..15 are inputs only while not set as outputs
        in_usable = {{16{panel_attached}}, ~io_dir_out, 12'hfff};
        next_alarm = '0;
        if (block_enable) begin
            next_alarm = in_provisioned & in_usable
                & (sync_b ^ in_alarm_on_open);
        end
        next_svc = next_alarm & in_svc_affect;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            alarm_active <= `ACC_IN_RST;
            alarm_svc_affect <= `ACC_IN_RST;
        end else begin
            alarm_active <= next_alarm;
            alarm_svc_affect <= next_svc;
        end
    end

    // ------------------------------------------------------------
    // Severity thresholds and virtual wires
    // ------------------------------------------------------------
    // sev_hit[l] is set when an active alarm is at level l or above;
    // eight entries so any level code indexes safely.
    logic [7:0] sev_hit;
    logic [7:0] rem_hit;
    logic [3:0] next_vwire;

    always_comb begin
        sev_hit = '0;
        rem_hit = '0;
        next_vwire = '0;
        for (int i = 0; i < `ACC_N_IN; i++) begin
            if (alarm_active[i]) begin
                for (int l = 0; l < 5; l++) begin
                    if (in_severity[i*3 +: 3] >= 3'(l)) begin
                        sev_hit[l] = 1'b1;
                    end
                end
                if (in_vwire_en[i]) begin
                    next_vwire[in_vwire_sel[i*2 +: 2]] = 1'b1;
                end
            end
        end
        for (int l = 0; l < 5; l++) begin
            if (remote_alarm_valid && remote_max_sev >= 3'(l)) begin
                rem_hit[l] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    logic [15:0] out_usable;
    logic [15:0] next_out;
    logic [2:0] lvl;

    always_comb begin
        out_usable = {{12{panel_attached}}, io_dir_out};
        next_out = '0;
        lvl = '0;
        for (int o = 0; o < `ACC_N_OUT; o++) begin
            lvl = out_trig_level[o*3 +: 3];
            case (acc_pkg::acc_force_e'(out_force[o*2 +: 2]))
                acc_pkg::ACC_FORCE_CLOSE: next_out[o] = 1'b1;
                acc_pkg::ACC_FORCE_OPEN: next_out[o] = 1'b0;
                default: begin
                    case (acc_pkg::acc_trig_e'(out_trig_mode[o*2 +: 2]))
                        acc_pkg::ACC_TRIG_LOCAL:
                            next_out[o] = sev_hit[lvl];
                        acc_pkg::ACC_TRIG_REMOTE:
                            next_out[o] = rem_hit[lvl];
                        acc_pkg::ACC_TRIG_VWIRE:
                            next_out[o] = vwire[out_vwire_sel[o*2 +: 2]];
                        default: next_out[o] = 1'b0;
                    endcase
                end
            endcase
        end
        // Unused or disabled outputs stay open
        next_out = next_out & out_usable & {16{block_enable}};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vwire <= '0;
            out_closed <= `ACC_OUT_RST;
            io_out <= '0;
            io_oe <= '0;
            panel_out <= '0;
        end else begin
            vwire <= next_vwire;
            out_closed <= next_out;
            io_out <= next_out[3:0];
            io_oe <= io_dir_out;
            panel_out <= next_out[15:4];
        end
    end

    // ------------------------------------------------------------
    // Description store
    // ------------------------------------------------------------
    // One slot per input; position 63 is never written and reads zero.
    logic [7:0] desc_mem [0:2047];
    logic [7:0] next_rd_char;

    always_comb begin
        next_rd_char = `ACC_CHAR_RST;
        if (desc_rd_pos < 6'(`ACC_DESC_LEN)) begin
            next_rd_char = desc_mem[{desc_rd_idx, desc_rd_pos}];
        end
    end

    always_ff @(posedge clk) begin
        if (desc_wr && desc_wr_pos < 6'(`ACC_DESC_LEN)) begin
            desc_mem[{desc_wr_idx, desc_wr_pos}] <= desc_wr_char;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            desc_rd_char <= `ACC_CHAR_RST;
        end else begin
            desc_rd_char <= next_rd_char;
        end
    end

    // ------------------------------------------------------------
    // Flash timebase
    // ------------------------------------------------------------
    // Shared by ring and fail indicators, so they blink in step.
    logic [31:0] flash_cnt;
    logic [31:0] next_flash_cnt;
    logic flash;
    logic next_flash;

    always_comb begin
        next_flash_cnt = flash_cnt + 32'h0000_0001;
        next_flash = flash;
        if (flash_cnt >= 32'(FLASH_HALF_CYC - 1)) begin
            next_flash_cnt = '0;
            next_flash = ~flash;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_cnt <= '0;
            flash <= 1'b0;
        end else begin
            flash_cnt <= next_flash_cnt;
            flash <= next_flash;
        end
    end

    // ------------------------------------------------------------
    // Faceplate indicators
    // ------------------------------------------------------------
    logic next_fail;

    always_comb begin
        next_fail = 1'b0;
        if (!cpu_ready) begin
            next_fail = booting ? flash : 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            input_led <= 1'b0;
            output_led <= 1'b0;
            pwr_a_green <= 1'b0;
            pwr_a_red <= 1'b0;
            pwr_b_green <= 1'b0;
            pwr_b_red <= 1'b0;
            ring_local_led <= 1'b0;
            ring_express_led <= 1'b0;
            fail_led <= 1'b1;
            act_led <= 1'b0;
        end else begin
            input_led <= |next_alarm;
            output_led <= |next_out;
            pwr_a_green <= pwr_a_ok;
            pwr_a_red <= ~pwr_a_ok;
            pwr_b_green <= pwr_b_ok;
            pwr_b_red <= ~pwr_b_ok;
            ring_local_led <= ring_local_call & flash;
            ring_express_led <= ring_express_call & flash;
            fail_led <= next_fail;
            act_led <= block_enable;
        end
    end

endmodule // acc_ctrl

/* File: verification/acc_ctrl_asserts.sv */
// Port checker for the alarm contact controller
`timescale 1ns/100ps
module acc_ctrl_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Contacts and setup
    input wire logic [31:0] contact_in,
    input wire logic block_enable,
    input wire logic panel_attached,
    input wire logic [3:0] io_dir_out,
    input wire logic [31:0] in_provisioned,
    input wire logic [31:0] in_alarm_on_open,
    input wire logic [31:0] out_force,
    // Outputs
    input wire logic [3:0] io_oe,
    input wire logic [3:0] io_out,
    input wire logic [11:0] panel_out,
    input wire logic [31:0] alarm_active,
    input wire logic [15:0] out_closed,
    input wire logic input_led,
    input wire logic output_led,
    // Indicators
    input wire logic pwr_a_ok,
    input wire logic pwr_a_green,
    input wire logic pwr_a_red,
    input wire logic cpu_ready,
    input wire logic booting,
    input wire logic fail_led
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------
    // Assertions
    // ----------------------------------------------------
    chk_input_led_sum:
        assert property (input_led == (alarm_active != 32'h0000_0000))
        else $error("input indicator disagrees with alarms");
    chk_output_led_sum:
        assert property (output_led == (out_closed != 16'h0000))
        else $error("output indicator disagrees with outputs");
    chk_alarm_latency:
        assert property ((block_enable && in_provisioned[0] &&
            !in_alarm_on_open[0] && contact_in[0])[*3] |=> alarm_active[0])
        else $error("closure alarm late");
    chk_force_close:
        assert property (block_enable && io_dir_out[0] &&
            out_force[1:0] == 2'h2 |=> out_closed[0] && io_out[0])
        else $error("forced close not applied");
    chk_force_open:
        assert property (out_force[1:0] == 2'h1 |=> !out_closed[0])
        else $error("forced open not applied");
    chk_panel_off:
        assert property (!panel_attached |=> panel_out == 12'h000)
        else $error("panel output without panel");
    chk_pin_dir:
        assert property (1'b1 |=> io_oe == $past(io_dir_out))
        else $error("pin direction not followed");
    chk_pwr_a_led:
        assert property (1'b1 |=> {pwr_a_green, pwr_a_red} ==
            {$past(pwr_a_ok), !$past(pwr_a_ok)})
        else $error("supply A indicator wrong");
    chk_fail_ready:
        assert property (cpu_ready |=> !fail_led)
        else $error("fail indicator lit while ready");
    chk_fail_steady:
        assert property (!cpu_ready && !booting |=> fail_led)
        else $error("fail indicator dark while not ready");
    cover property ($rose(alarm_active[0]));
    cover property (out_closed[0] && io_out[0]);
    cover property (panel_out[0]);
endmodule // acc_ctrl_asserts

bind acc_ctrl acc_ctrl_asserts acc_ctrl_asserts_i (.*);

/* File: verification/acc_contact_model.sv */
// Contact-side model: sensors and the four two-way pins
`timescale 1ns/100ps
module acc_contact_model (
    // Sensor states from the bench, closed = 1
    input wire logic [31:0] sensor,
    // Design side of the two-way pins
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe,
    // Contact levels seen by the design
    output logic [31:0] contact_in
);
    // A pin turned to output reads back its own relay, not the sensor
    always_comb begin
        contact_in = sensor;
        for (int k = 0; k < 4; k++) begin
            if (io_oe[k]) begin
                contact_in[12 + k] = io_out[k];
            end
        end
    end
endmodule // acc_contact_model

/* File: verification/tb.sv */
// Self-checking testbench for the alarm contact controller
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
    // ----------------------------------------------------
    // Signals
    // ----------------------------------------------------
    logic clk, nrst, block_enable, panel_attached, desc_wr;
    logic remote_alarm_valid, pwr_a_ok, pwr_b_ok, ring_local_call;
    logic ring_express_call, cpu_ready, booting;
    logic [3:0] io_dir_out, io_out, io_oe, vwire;
    logic [31:0] sensor, contact_in, in_provisioned, in_alarm_on_open;
    logic [31:0] in_svc_affect, in_vwire_en, out_trig_mode, out_vwire_sel;
    logic [31:0] out_force, alarm_active, alarm_svc_affect;
    logic [95:0] in_severity;
    logic [63:0] in_vwire_sel;
    logic [47:0] out_trig_level;
    logic [4:0] desc_wr_idx, desc_rd_idx;
    logic [5:0] desc_wr_pos, desc_rd_pos;
    logic [7:0] desc_wr_char, desc_rd_char;
    logic [2:0] remote_max_sev;
    logic [11:0] panel_out;
    logic [15:0] out_closed;
    logic input_led, output_led, pwr_a_green, pwr_a_red, pwr_b_green;
    logic pwr_b_red, ring_local_led, ring_express_led, fail_led, act_led;
    int failures, compares;
    // Short flash period keeps the indicator checks brief
    acc_ctrl #(.FLASH_HALF_CYC(4)) acc_ctrl_i (.*);
    acc_contact_model acc_contact_model_i (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------
    // Scenarios
    // ----------------------------------------------------
    task automatic t_leds;
        int nf, nr;
        `CHK("pwr", 4'b1001, {pwr_a_green, pwr_a_red, pwr_b_green, pwr_b_red})
        `CHK("fail_nrdy", 1'b1, fail_led)
        {booting, ring_local_call} = 2'b11;
        cyc(1);
        nf = 0;
        nr = 0;
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            nf += (fail_led === 1'b1);
            nr += (ring_local_led === 1'b1);
            `CHK("ring_exp", 1'b0, ring_express_led)
        end
        `CHK("boot_flash", 8, nf)
        `CHK("ring_flash", 8, nr)
        {ring_local_call, ring_express_call} = 2'b01;
        nr = 0;
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            nr += (ring_express_led === 1'b1);
            `CHK("ring_loc_off", 1'b0, ring_local_led)
        end
        `CHK("ring_exp_flash", 8, nr)
        {cpu_ready, block_enable, ring_express_call} = 3'b110;
        cyc(2);
        `CHK("ready", 2'b01, {fail_led, act_led})
    endtask
    task automatic t_alarms;
        in_provisioned = 32'h0000_0003;
        in_alarm_on_open = 32'h0000_0002;
        in_svc_affect = 32'h0000_0001;
        in_severity[5:0] = {acc_pkg::ACC_SEV_MAJOR, acc_pkg::ACC_SEV_MINOR};
        cyc(4);
        `CHK("open_alarm", 33'h1_0000_0002, {input_led, alarm_active})
        sensor[1:0] = 2'b11;
        cyc(3);
        `CHK("close_alarm", 32'h0000_0001, alarm_active)
        `CHK("svc", 32'h0000_0001, alarm_svc_affect)
        cyc(20);
        `CHK("hold", 32'h0000_0001, alarm_active)
        in_provisioned = 32'h0000_0000;
        cyc(2);
        `CHK("unprov", 33'h0, {input_led, alarm_active})
        in_provisioned = 32'h0000_0001;
    endtask
    task automatic t_local;
        io_dir_out = 4'h1;
        out_trig_mode[1:0] = acc_pkg::ACC_TRIG_LOCAL;
        for (int l = 0; l < 5; l++) begin
            out_trig_level[2:0] = 3'(l);
            cyc(3);
            `CHK("local", 3'(l <= 2) * 3'h7, {out_closed[0], io_out[0], output_led})
        end
        `CHK("pin_oe", 4'h1, io_oe)
    endtask
    task automatic t_remote;
        io_dir_out = 4'h3;
        remote_alarm_valid = 1'b1;
        out_trig_mode[3:2] = acc_pkg::ACC_TRIG_REMOTE;
        out_trig_level[5:3] = acc_pkg::ACC_SEV_MAJOR;
        for (int s = 0; s < 5; s++) begin
            remote_max_sev = 3'(s);
            cyc(2);
            `CHK("remote", 1'(s >= 3), out_closed[1])
        end
    endtask
    task automatic t_vwire;
        io_dir_out = 4'h7;
        in_provisioned[2] = 1'b1;
        in_vwire_en[2] = 1'b1;
        in_vwire_sel[5:4] = 2'h3;
        out_trig_mode[5:4] = acc_pkg::ACC_TRIG_VWIRE;
        out_vwire_sel[5:4] = 2'h3;
        sensor[2] = 1'b1;
        cyc(6);
        `CHK("vwire", 5'h18, {out_closed[2], vwire})
        sensor[2] = 1'b0;
        cyc(6);
        `CHK("vwire_off", 5'h00, {out_closed[2], vwire})
    endtask
    task automatic t_force;
        io_dir_out = 4'hf;
        out_force[1:0] = acc_pkg::ACC_FORCE_CLOSE;
        out_force[7:6] = acc_pkg::ACC_FORCE_CLOSE;
        cyc(2);
        `CHK("f_close", 4'hf, {out_closed[3], io_out[3], out_closed[0],
            io_out[0]})
        out_trig_level[2:0] = 3'h0;
        out_force[1:0] = acc_pkg::ACC_FORCE_OPEN;
        cyc(3);
        `CHK("f_open", 1'b0, out_closed[0])
        out_force[7:6] = acc_pkg::ACC_FORCE_NONE;
        cyc(2);
        `CHK("manual", 1'b0, out_closed[3])
    endtask
    task automatic t_panel;
        out_force[9:8] = acc_pkg::ACC_FORCE_CLOSE;
        in_provisioned[20] = 1'b1;
        sensor[20] = 1'b1;
        cyc(5);
        `CHK("no_panel", 2'b00, {panel_out[0], alarm_active[20]})
        panel_attached = 1'b1;
        cyc(2);
        `CHK("panel", 3'b111, {panel_out[0], out_closed[4], alarm_active[20]})
    endtask
    task automatic t_desc;
        {desc_wr, desc_wr_idx, desc_wr_pos, desc_wr_char} = {1'b1, 5'h05, 6'h3e, 8'h5a};
        cyc(1);
        desc_wr = 1'b0;
        {desc_rd_idx, desc_rd_pos} = {5'h05, 6'h3e};
        cyc(1);
        `CHK("desc", 8'h5a, desc_rd_char)
        desc_rd_pos = 6'h3f;
        cyc(1);
        `CHK("desc_end", 8'h00, desc_rd_char)
    endtask
    initial begin
        {block_enable, panel_attached, desc_wr, remote_alarm_valid} = '0;
        {ring_local_call, ring_express_call, cpu_ready, booting} = '0;
        {pwr_a_ok, pwr_b_ok} = 2'b10;
        {io_dir_out, sensor, in_provisioned, in_alarm_on_open} = '0;
        {in_svc_affect, in_vwire_en, out_trig_mode, out_vwire_sel} = '0;
        {out_force, in_severity, in_vwire_sel, out_trig_level} = '0;
        {desc_wr_idx, desc_rd_idx, desc_wr_pos, desc_rd_pos} = '0;
        {desc_wr_char, remote_max_sev} = '0;
        failures = 0;
        compares = 0;
        nrst = 1'b0;
        cyc(5);
        `CHK("rst_fail", 2'b10, {fail_led, act_led})
        nrst = 1'b1;
        cyc(3);
        t_leds();
        t_alarms();
        t_local();
        t_remote();
        t_vwire();
        t_force();
        t_panel();
        t_desc();
        tally_and_finish();
    end
endmodule // tb
